// ---- verilog/hbc_pkg.sv ----
// Package for the H-bridge control logic: register map, field positions,
// reset values, timing counts and shared types.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
`default_nettype none
package hbc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
    localparam int unsigned DEAD_TIME_NS   = 500;
    // Least time, so round up; never below one cycle
    localparam int unsigned DEAD_CYC_RAW   = (DEAD_TIME_NS * (CLK_FREQ_HZ / 1_000_000)
                                              + 999) / 1000;
    localparam int unsigned DEAD_CYCLES    = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
    localparam int unsigned DEAD_CNT_W     = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] STATUS_OFS     = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS   = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h0C;
    localparam logic [7:0] ID_OFS         = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_FIRST_BIT  = 0;
    localparam int unsigned CTRL_SECOND_BIT = 1;
    localparam int unsigned CTRL_SRC_BIT    = 2;
    localparam int unsigned CTRL_SCHEME_BIT = 3;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;

    // Interrupt status / mask fields (same layout)
    localparam int unsigned IRQ_UV_BIT   = 0;
    localparam int unsigned IRQ_OC_BIT   = 1;
    localparam int unsigned IRQ_OT_BIT   = 2;
    localparam int unsigned IRQ_OV_BIT   = 3;
    localparam int unsigned IRQ_W        = 4;
    localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

    // Identification word, value is arbitrary
    localparam logic [31:0] ID_VALUE     = 32'h4842_0001;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Half-bridge drive levels
    typedef enum logic [1:0] {
        HB_OFF  = 2'h0,   // Both switches off (high impedance)
        HB_LOW  = 2'h1,   // Low-side switch on
        HB_HIGH = 2'h2    // High-side switch on
    } hbc_drive_e;

    // Requested drive for the full bridge
    typedef struct packed {
        hbc_drive_e a;
        hbc_drive_e b;
    } hbc_bridge_s;

    // Analog protection comparator flags
    typedef struct packed {
        logic ov;
        logic ot;
        logic oc;
        logic uv;
    } hbc_fault_s;

endpackage
`default_nettype wire

// ---- verilog/hbc_half_bridge.sv ----
// One half-bridge gate sequencer with shoot-through protection.
// Assumes the requested drive level is synchronous to CLK.
`default_nettype none
module hbc_half_bridge
    import hbc_pkg::*;
#(
    parameter int unsigned DEAD_CYC = DEAD_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire hbc_drive_e req,
    output logic            hs_on,
    output logic            ls_on
);

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_DEAD = 3'b010,
        ST_ON   = 3'b100
    } hbc_hb_state_e;

    hbc_hb_state_e         state_q;
    hbc_hb_state_e         state_d;
    hbc_drive_e            cur_q;
    hbc_drive_e            cur_d;
    logic [DEAD_CNT_W-1:0] cnt_q;
    logic [DEAD_CNT_W-1:0] cnt_d;

    // Release or swap waits out the gap; a one-cycle off is too short
    wire opposite = (req != HB_OFF) && (cur_q != HB_OFF) && (req != cur_q);
    wire cnt_done = (cnt_q == DEAD_CNT_W'(DEAD_CYC - 1));

    //////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_OFF: begin
                if (req != HB_OFF) begin
                    cur_d   = req;
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if ((req == HB_OFF) || opposite) begin
                    cnt_d   = '0;        // Dead interval, output high-Z
                    state_d = ST_DEAD;
                end
            end
            ST_DEAD: begin
                cnt_d = cnt_q + DEAD_CNT_W'(1);
                if (cnt_done) begin
                    cur_d   = req;       // Opposite switch only after the gap
                    state_d = (req == HB_OFF) ? ST_OFF : ST_ON;
                end
            end
            default: begin
                cur_d   = HB_OFF;
                state_d = ST_OFF;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_OFF;
            cur_q   <= HB_OFF;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cur_q   <= cur_d;
            cnt_q   <= cnt_d;
        end
    end

    // Gate outputs decoded from registers only, never both high
    assign hs_on = (state_q == ST_ON) && (cur_q == HB_HIGH);
    assign ls_on = (state_q == ST_ON) && (cur_q == HB_LOW);

endmodule
`default_nettype wire

// ---- verilog/hbc_top.sv ----
// H-bridge control logic: command source and decode, sleep, protection
// braking, dead-time sequencing, fault pin and an AXI4-Lite register port.
// Assumes all pins are synchronous to CLK and the protection comparator
// flags arrive already deglitched from the analog side.
`default_nettype none
module hbc_top
    import hbc_pkg::*;
#(
    parameter int unsigned DEAD_CYC = DEAD_CYCLES,
    parameter int unsigned ADDR_W   = 8
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    // Bridge command pins
    input  wire logic              FIRST_COMMAND_PIN,
    input  wire logic              SECOND_COMMAND_PIN,
    input  wire logic              SLEEP_REQUEST_N,
    // Protection comparator flags
    input  wire hbc_fault_s        FAULT_IN,
    // Gate drive for the two half-bridges
    output logic                   BRIDGE_OUTPUT_A_HS,
    output logic                   BRIDGE_OUTPUT_A_LS,
    output logic                   BRIDGE_OUTPUT_B_HS,
    output logic                   BRIDGE_OUTPUT_B_LS,
    // Open-drain fault pin: output level and enable
    output logic                   FAULT_FLAG_N_O,
    output logic                   FAULT_FLAG_N_OE,
    output logic                   IRQ,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [3:0]        ctrl_q;
    logic [IRQ_W-1:0]  irq_stat_q;
    logic [IRQ_W-1:0]  irq_stat_d;
    logic [IRQ_W-1:0]  irq_mask_q;

    // Write channel
    logic [ADDR_W-1:0] awaddr_q;
    logic              aw_held_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              w_held_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    // Read channel
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;

    // Fault pin
    logic              fault_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Control fields
    wire first_command_regbit  = ctrl_q[CTRL_FIRST_BIT];
    wire second_command_regbit = ctrl_q[CTRL_SECOND_BIT];
    wire bridge_source_select  = ctrl_q[CTRL_SRC_BIT];
    wire decode_scheme_select  = ctrl_q[CTRL_SCHEME_BIT];

    // Command source mux; register bits allow pin-free operation
    wire cmd_first  = bridge_source_select ? first_command_regbit
                                           : FIRST_COMMAND_PIN;
    wire cmd_second = bridge_source_select ? second_command_regbit
                                           : SECOND_COMMAND_PIN;

    // Sleep pin is active low
    wire awake      = SLEEP_REQUEST_N;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the requested bridge state
    hbc_bridge_s pe_req;
    hbc_bridge_s pwm_req;
    hbc_bridge_s dec_req;
    hbc_bridge_s bridge_req;

    // Phase/enable: enable low brakes, phase picks direction
    always_comb begin
        if (!cmd_first) begin
            pe_req = '{a: HB_LOW,  b: HB_LOW};
        end else if (cmd_second) begin
            pe_req = '{a: HB_HIGH, b: HB_LOW};
        end else begin
            pe_req = '{a: HB_LOW,  b: HB_HIGH};
        end
    end

    // Two-input PWM: coast, reverse, forward, brake
    always_comb begin
        unique case ({cmd_first, cmd_second})
            2'b00:   pwm_req = '{a: HB_OFF,  b: HB_OFF};
            2'b01:   pwm_req = '{a: HB_LOW,  b: HB_HIGH};
            2'b10:   pwm_req = '{a: HB_HIGH, b: HB_LOW};
            default: pwm_req = '{a: HB_LOW,  b: HB_LOW};
        endcase
    end

    // Scheme select
    assign dec_req = decode_scheme_select ? pwm_req : pe_req;

    // Bridge counts as disabled when asleep, or when the decode leaves it
    // coasting; overvoltage then brakes to clamp back-EMF. Shutdown faults
    // otherwise keep the bridge off.
    wire bridge_idle = !awake || (dec_req.a == HB_OFF && dec_req.b == HB_OFF);
    wire shut_fault  = FAULT_IN.uv || FAULT_IN.oc || FAULT_IN.ot;

    always_comb begin
        if (FAULT_IN.ov && bridge_idle) begin
            bridge_req = '{a: HB_LOW, b: HB_LOW};
        end else if (!awake || shut_fault) begin
            bridge_req = '{a: HB_OFF, b: HB_OFF};
        end else begin
            bridge_req = dec_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dead-time sequencers, one per half-bridge
    // Half A
    hbc_half_bridge #(
        .DEAD_CYC (DEAD_CYC)
    ) u_hb_a (
        .clk   (CLK),
        .rst   (RST),
        .req   (bridge_req.a),
        .hs_on (BRIDGE_OUTPUT_A_HS),
        .ls_on (BRIDGE_OUTPUT_A_LS)
    );

    // Half B
    hbc_half_bridge #(
        .DEAD_CYC (DEAD_CYC)
    ) u_hb_b (
        .clk   (CLK),
        .rst   (RST),
        .req   (bridge_req.b),
        .hs_on (BRIDGE_OUTPUT_B_HS),
        .ls_on (BRIDGE_OUTPUT_B_LS)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fault pin: open drain, driven only while pulling low
    always_ff @(posedge CLK) begin
        if (RST) begin
            fault_n_q <= 1'b1;
        end else begin
            fault_n_q <= !shut_fault;
        end
    end

    // Never driven high; the board pull-up releases it
    assign FAULT_FLAG_N_O  = 1'b0;
    assign FAULT_FLAG_N_OE = !fault_n_q;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: address and data accepted in either order
    wire aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take   = S_AXI_WVALID && S_AXI_WREADY;
    wire aw_have  = aw_held_q || aw_take;
    wire w_have   = w_held_q || w_take;
    wire do_write = aw_have && w_have && !bvalid_q;

    // A parked beat is used ahead of the live bus
    wire [ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : S_AXI_AWADDR;
    wire [31:0]       wr_data = w_held_q ? wdata_q : S_AXI_WDATA;
    wire [3:0]        wr_strb = w_held_q ? wstrb_q : S_AXI_WSTRB;
    wire              wr_lane = wr_strb[0];
    // Decoded write targets
    wire              wr_ctrl = do_write && wr_addr == ADDR_W'(CTRL_OFS) && wr_lane;
    wire              wr_mask = do_write && wr_addr == ADDR_W'(IRQ_MASK_OFS) && wr_lane;
    wire              wr_ok   = wr_addr == ADDR_W'(CTRL_OFS) ||
                                wr_addr == ADDR_W'(STATUS_OFS) ||
                                wr_addr == ADDR_W'(IRQ_STAT_OFS) ||
                                wr_addr == ADDR_W'(IRQ_MASK_OFS) ||
                                wr_addr == ADDR_W'(ID_OFS);

    // Ready drops while a beat is parked or the response is pending
    assign S_AXI_AWREADY = !aw_held_q && !bvalid_q;
    assign S_AXI_WREADY  = !w_held_q && !bvalid_q;
    assign S_AXI_BVALID  = bvalid_q;
    assign S_AXI_BRESP   = bresp_q;

    // Parked beats and write response
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_q <= 1'b1;
                    awaddr_q  <= S_AXI_AWADDR;
                end
                if (w_take) begin
                    w_held_q <= 1'b1;
                    wdata_q  <= S_AXI_WDATA;
                    wstrb_q  <= S_AXI_WSTRB;
                end
                if (bvalid_q && S_AXI_BREADY) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // Control and mask registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_q     <= CTRL_RESET;
            irq_mask_q <= IRQ_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wr_data[3:0];
            end
            if (wr_mask) begin
                irq_mask_q <= wr_data[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path, one outstanding read
    wire ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;
    // Reading the event register clears it
    wire rd_istat = ar_take && S_AXI_ARADDR == ADDR_W'(IRQ_STAT_OFS);

    // Live status; not sticky, unlike the event bits
    wire [31:0] status_word = {27'h0, fault_n_q, !awake, FAULT_IN.ov, shut_fault,
                               BRIDGE_OUTPUT_A_HS || BRIDGE_OUTPUT_A_LS ||
                               BRIDGE_OUTPUT_B_HS || BRIDGE_OUTPUT_B_LS};

    logic [31:0] rd_word;
    logic        rd_hit;

    // Read decode; unmapped offsets answer SLVERR with zero data
    always_comb begin
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            ADDR_W'(CTRL_OFS):     rd_word = {28'h0, ctrl_q};
            ADDR_W'(STATUS_OFS):   rd_word = status_word;
            ADDR_W'(IRQ_STAT_OFS): rd_word = {28'h0, irq_stat_q};
            ADDR_W'(IRQ_MASK_OFS): rd_word = {28'h0, irq_mask_q};
            ADDR_W'(ID_OFS):       rd_word = ID_VALUE;
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // A new address waits until the read data is taken
    assign S_AXI_ARREADY = !rvalid_q;
    assign S_AXI_RVALID  = rvalid_q;
    assign S_AXI_RDATA   = rdata_q;
    assign S_AXI_RRESP   = rresp_q;

    // Read data register
    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event bits: a read clears, but a new event in the same
    // cycle wins so no event is lost
    wire [IRQ_W-1:0] events = {FAULT_IN.ov, FAULT_IN.ot, FAULT_IN.oc, FAULT_IN.uv};

    always_comb begin
        irq_stat_d = rd_istat ? '0 : irq_stat_q;
        irq_stat_d = irq_stat_d | events;
    end

    // Event register
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // Level interrupt while any unmasked bit is set
    assign IRQ = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// ---- tb/hbc_top_monitor.sv ----
// Concurrent checks on the ports of the H-bridge control top level.
// Assumes one clock domain and DEAD_CYC of at least one cycle.
`default_nettype none
module hbc_top_monitor
    import hbc_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic       SLEEP_REQUEST_N,
    input wire hbc_fault_s FAULT_IN,
    input wire logic       BRIDGE_OUTPUT_A_HS,
    input wire logic       BRIDGE_OUTPUT_A_LS,
    input wire logic       BRIDGE_OUTPUT_B_HS,
    input wire logic       BRIDGE_OUTPUT_B_LS,
    input wire logic       FAULT_FLAG_N_O,
    input wire logic       FAULT_FLAG_N_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shutdown faults that pull the pin low; overvoltage brakes an idle bridge instead
    wire logic shut_req = FAULT_IN.uv | FAULT_IN.oc | FAULT_IN.ot;
    wire logic a_off = !BRIDGE_OUTPUT_A_HS && !BRIDGE_OUTPUT_A_LS;
    wire logic b_off = !BRIDGE_OUTPUT_B_HS && !BRIDGE_OUTPUT_B_LS;

    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    ////////////////////////////////////////////////////////////////////////
    // Shoot-through would short the supply, so both sides are watched
    a_no_shoot_a: assert property (!(BRIDGE_OUTPUT_A_HS && BRIDGE_OUTPUT_A_LS))
        else $error("half A high and low side on together");
    a_no_shoot_b: assert property (!(BRIDGE_OUTPUT_B_HS && BRIDGE_OUTPUT_B_LS))
        else $error("half B high and low side on together");
    a_dead_a_fall: assert property (BRIDGE_OUTPUT_A_HS |=> !BRIDGE_OUTPUT_A_LS)
        else $error("half A swapped high to low with no gap");
    a_dead_b_rise: assert property ($rose(BRIDGE_OUTPUT_B_HS) |-> !$past(BRIDGE_OUTPUT_B_LS))
        else $error("half B swapped low to high with no gap");
    a_sleep_off: assert property (!SLEEP_REQUEST_N && !FAULT_IN.ov |=> a_off && b_off)
        else $error("bridge driven while asleep");
    a_ov_brake: assert property ((FAULT_IN.ov && !SLEEP_REQUEST_N) [*6] |->
        BRIDGE_OUTPUT_A_LS && BRIDGE_OUTPUT_B_LS && !BRIDGE_OUTPUT_A_HS && !BRIDGE_OUTPUT_B_HS)
        else $error("no brake under overvoltage in sleep");
    a_fault_follows: assert property (!RST |=> FAULT_FLAG_N_OE == $past(shut_req))
        else $error("fault pin enable does not follow shutdown faults");
    a_fault_low: assert property (FAULT_FLAG_N_OE |-> !FAULT_FLAG_N_O)
        else $error("fault pin driven high");

    // Main scenarios reached
    cover property ($fell(BRIDGE_OUTPUT_A_HS) ##[1:4] BRIDGE_OUTPUT_A_LS);
    cover property (!FAULT_FLAG_N_OE ##1 FAULT_FLAG_N_OE);
    cover property (FAULT_IN.ov && BRIDGE_OUTPUT_A_LS && BRIDGE_OUTPUT_B_LS);
endmodule
`default_nettype wire

// ---- tb/hbc_mcu_model.sv ----
// Controller model: drives the two command pins static or modulates the first.
// Assumes a 100 MHz clock, so HALF of 250 gives the fastest 200 kHz rate.
`default_nettype none
module hbc_mcu_model #(
    parameter int unsigned HALF = 250
) (
    input  wire logic clk,
    input  wire logic pwm_en,
    input  wire logic lvl1,
    input  wire logic lvl2,
    output logic      pin1,
    output logic      pin2
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt_q;

    initial begin
        pin1 = 1'h0;
        pin2 = 1'h0;
        cnt_q = 0;
    end

    // Pins change only after a clock edge, like a real port register
    always @(posedge clk) begin
        cnt_q <= (cnt_q + 1 >= HALF) ? 0 : cnt_q + 1;
        pin2 <= lvl2;
        if (!pwm_en) begin
            pin1 <= lvl1;
        end else if (cnt_q + 1 >= HALF) begin
            pin1 <= ~pin1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/hbc_top_bench.sv ----
// Self-checking bench for the H-bridge control top level.
// Assumes the package, design, controller model and checker compile first.
`default_nettype none
module hbc_top_bench
    import hbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, sleep_n = 1'h0, pwm_en = 1'h0, lvl1 = 1'h0, lvl2 = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    hbc_fault_s flt = '0;
    logic p1, p2, a_hs, a_ls, b_hs, b_ls, fo, foe, irq;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int cmp_count = 0;
    wire logic [3:0] g = {a_hs, a_ls, b_hs, b_ls};
    wire logic fault_pin = foe ? fo : 1'h1;  // Pull-up holds the pin when released

    always #5 clk = ~clk;

    hbc_top #(.DEAD_CYC(2)) hbc_top_inst (
        .CLK(clk), .RST(rst), .FIRST_COMMAND_PIN(p1), .SECOND_COMMAND_PIN(p2),
        .SLEEP_REQUEST_N(sleep_n), .FAULT_IN(flt), .BRIDGE_OUTPUT_A_HS(a_hs),
        .BRIDGE_OUTPUT_A_LS(a_ls), .BRIDGE_OUTPUT_B_HS(b_hs), .BRIDGE_OUTPUT_B_LS(b_ls),
        .FAULT_FLAG_N_O(fo), .FAULT_FLAG_N_OE(foe), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    hbc_mcu_model hbc_mcu_model_inst (.clk(clk), .pwm_en(pwm_en), .lvl1(lvl1), .lvl2(lvl2),
        .pin1(p1), .pin2(p2));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Gates settle through dead time, so allow a bounded wait first
    task automatic chk_g(input logic [3:0] exp);
        repeat (12) begin
            @(negedge clk);
            if (g === exp) break;
        end
        chk32("gates", {28'h0, exp}, {28'h0, g});
        if (g !== exp) wrap_up();
    endtask

    task automatic hang(input string nm);
        err_total++;
        $display("[FAIL] %s expected answer seen timeout", nm);
        wrap_up();
    endtask

    // Ready is sampled at the falling edge, before the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tb) begin
                bready <= 1'h0;
                chk32("bresp", {30'h0, er}, {30'h0, r});
                return;
            end
        end
        hang("write");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            if (tr) begin
                rready <= 1'h0;
                chk32("rdata", ed, d);
                chk32("rresp", {30'h0, er}, {30'h0, r});
                return;
            end
        end
        hang("read");
    endtask

    // v is {sleep_n, source, scheme, first, second}; gates {A_HS, A_LS, B_HS, B_LS}
    function automatic logic [3:0] expg(input logic [4:0] v);
        if (!v[4]) return 4'h0;
        if (v[2]) begin
            case (v[1:0])
                2'h0: return 4'h0;
                2'h1: return 4'h6;
                2'h2: return 4'h9;
                default: return 4'h5;
            endcase
        end
        if (!v[1]) return 4'h5;
        return v[0] ? 4'h9 : 4'h6;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [4:0] v;
        void'($urandom(32'hC145B29F));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        // Reset values, a read-only word and an unmapped place
        rd(CTRL_OFS, {28'h0, CTRL_RESET}, RESP_OKAY);
        rd(IRQ_MASK_OFS, {28'h0, IRQ_MASK_RESET}, RESP_OKAY);
        wr(ID_OFS, 32'h0, RESP_OKAY);
        rd(ID_OFS, ID_VALUE, RESP_OKAY);
        wr(8'h20, 32'hF, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        // All command combinations, then random ones; the idle source carries noise
        for (int i = 0; i < 64; i++) begin
            v = (i < 32) ? i[4:0] : 5'($urandom);
            @(posedge clk);
            sleep_n <= v[4];
            lvl1 <= v[3] ? 1'($urandom) : v[1];
            lvl2 <= v[3] ? 1'($urandom) : v[0];
            wr(CTRL_OFS, {28'h0, v[2], v[3], v[3] ? v[0] : 1'($urandom),
                v[3] ? v[1] : 1'($urandom)}, RESP_OKAY);
            chk_g(expg(v));
        end
        // Enable modulated at the fastest rate, then held high
        @(posedge clk);
        sleep_n <= 1'h1;
        lvl2 <= 1'h1;
        pwm_en <= 1'h1;
        wr(CTRL_OFS, 32'h0, RESP_OKAY);
        repeat (1000) @(posedge clk);
        pwm_en <= 1'h0;
        lvl1 <= 1'h1;
        chk_g(4'h9);
        // Shutdown faults: pin, interrupt masking, sticky status cleared by read
        wr(IRQ_MASK_OFS, 32'h2, RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            flt <= 4'(1 << k);
            chk_g(4'h0);
            chk32("fault pin", 32'h0, {31'h0, fault_pin});
            @(posedge clk);
            flt <= '0;
            @(negedge clk);
            chk32("irq", {31'h0, k == 1}, {31'h0, irq});
            rd(IRQ_STAT_OFS, 32'(1 << k), RESP_OKAY);
            rd(IRQ_STAT_OFS, 32'h0, RESP_OKAY);
            @(negedge clk);
            chk32("irq", 32'h0, {31'h0, irq});
        end
        // Overvoltage while asleep, then while coasting awake
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            sleep_n <= k[0];
            wr(CTRL_OFS, k ? 32'hC : 32'h0, RESP_OKAY);
            @(posedge clk);
            flt <= 4'h8;
            chk_g(4'h5);
            rd(STATUS_OFS, k ? 32'h15 : 32'h1D, RESP_OKAY);
            repeat (3) @(posedge clk);
            @(posedge clk);
            flt <= '0;
            chk_g(4'h0);
        end
        wrap_up();
    end
endmodule

bind hbc_top hbc_top_monitor hbc_top_monitor_inst (
    .CLK(CLK), .RST(RST), .SLEEP_REQUEST_N(SLEEP_REQUEST_N), .FAULT_IN(FAULT_IN),
    .BRIDGE_OUTPUT_A_HS(BRIDGE_OUTPUT_A_HS), .BRIDGE_OUTPUT_A_LS(BRIDGE_OUTPUT_A_LS),
    .BRIDGE_OUTPUT_B_HS(BRIDGE_OUTPUT_B_HS), .BRIDGE_OUTPUT_B_LS(BRIDGE_OUTPUT_B_LS),
    .FAULT_FLAG_N_O(FAULT_FLAG_N_O), .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE));
`default_nettype wire
